//--- epf_pause_ctl.sv
// Purpose: receive pause validation and request tracking, transmit pause
//          scheduling with refresh and resend.
// Assumes: parser and framer sit on core_clk_in; no synchronisers needed.
// Notes:   one frame in flight at a time; global pause goes before priority.

module epf_pause_ctl (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic rx_ctl_valid_in,
  input wire epf_pkg::epf_rx_ctl_t rx_ctl_in,
  input wire logic [47:0] station_addr_in,
  input wire logic [47:0] pause_src_addr_in,
  input wire logic glob_pause_rx_en_in,
  input wire logic glob_pause_chk_unicast_da_in,
  input wire logic glob_pause_chk_src_addr_in,
  input wire logic glob_pause_chk_ethertype_in,
  input wire logic glob_pause_chk_opcode_in,
  input wire logic prio_pause_rx_en_in,
  input wire logic prio_pause_chk_multicast_da_in,
  input wire logic prio_pause_chk_unicast_da_in,
  input wire logic prio_pause_chk_src_addr_in,
  input wire logic prio_pause_chk_ethertype_in,
  input wire logic prio_pause_chk_opcode_in,
  input wire logic [8:0] rx_pause_prio_enable_in,
  input wire logic [8:0] rx_pause_acknowledge_in,
  output logic [8:0] rx_pause_req_out,
  output logic [8:0] rx_pause_valid_out,
  output logic [8:0][15:0] rx_pause_quanta_out,
  input wire logic [8:0] tx_pause_request_in,
  input wire logic [8:0][15:0] tx_pause_quanta_in,
  input wire logic [8:0][15:0] tx_pause_refresh_interval_in,
  input wire logic tx_pause_resend_in,
  input wire logic [8:0] tx_pause_prio_enable_in,
  output logic tx_ctl_valid_out,
  output epf_pkg::epf_tx_ctl_t tx_ctl_out,
  input wire logic tx_ctl_ready_in,
  input wire logic tx_ctl_done_in,
  output logic [8:0] tx_pause_valid_out
);
  import epf_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_OFFER, TX_FLIGHT} epf_tx_state_t;

  logic da_is_mcast, da_is_ucast, sa_ok, etype_ok;
  logic g_ok, p_ok;
  logic [8:0] rx_hit;
  logic [8:0] req_reg;
  logic [8:0] rx_valid_reg;
  logic [8:0][15:0] rx_quanta_reg;

  // Field compares for both frame kinds; the multicast DA compare is used by the priority checks only
  assign da_is_mcast = rx_ctl_in.da == MCAST_CTL_DA;
  assign da_is_ucast = rx_ctl_in.da == station_addr_in;
  assign sa_ok = rx_ctl_in.sa == pause_src_addr_in;
  assign etype_ok = rx_ctl_in.etype == ETYPE_MAC_CTL;

  // global checks
  // An odd opcode with checks off is a candidate for both kinds
  assign g_ok = rx_ctl_valid_in && glob_pause_rx_en_in
    && (rx_ctl_in.opcode != OPC_PRIO)
    && (!glob_pause_chk_unicast_da_in || da_is_ucast)
    && (!glob_pause_chk_src_addr_in || sa_ok)
    && (!glob_pause_chk_ethertype_in || etype_ok)
    && (!glob_pause_chk_opcode_in || rx_ctl_in.opcode == OPC_GLOBAL);

  // priority checks
  // DA passes on any enabled match, or freely when both are off
  assign p_ok = rx_ctl_valid_in && prio_pause_rx_en_in
    && (rx_ctl_in.opcode != OPC_GLOBAL)
    && ((!prio_pause_chk_multicast_da_in && !prio_pause_chk_unicast_da_in)
        || (prio_pause_chk_multicast_da_in && da_is_mcast)
        || (prio_pause_chk_unicast_da_in && da_is_ucast))
    && (!prio_pause_chk_src_addr_in || sa_ok)
    && (!prio_pause_chk_ethertype_in || etype_ok)
    && (!prio_pause_chk_opcode_in || rx_ctl_in.opcode == OPC_PRIO);

  // Global wins if a frame qualifies as both
  assign rx_hit = g_ok ? {1'b1, 8'h00} : (p_ok ? {1'b0, rx_ctl_in.class_en} : CH_NONE);

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_rxq
      always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
          rx_quanta_reg[gi] <= TIMER_RST;
        end else if (rx_hit[gi]) begin
          rx_quanta_reg[gi] <= rx_ctl_in.quanta[(gi == GLOB_IDX) ? 0 : gi];
        end
      end
    end
  endgenerate

  // request hold; a new frame beats a same-cycle acknowledge
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      req_reg <= CH_NONE;
      rx_valid_reg <= CH_NONE;
    end else begin
      req_reg <= (req_reg & ~rx_pause_acknowledge_in) | rx_hit;
      rx_valid_reg <= rx_hit;
    end
  end

  // enable masks only what the user sees
  assign rx_pause_req_out = req_reg & rx_pause_prio_enable_in;
  assign rx_pause_valid_out = rx_valid_reg & rx_pause_prio_enable_in;
  assign rx_pause_quanta_out = rx_quanta_reg;

  // Transmit side
  epf_tx_state_t state_reg;
  logic [8:0] tx_active, active_d_reg, pend_reg, pend_next, expire, restart;
  logic [8:0] issue_bits, sent_reg, tx_vld_reg;
  logic [8:0] pend_live;
  logic issue;
  epf_tx_ctl_t frame_reg;

  // channel live only while requested and enabled
  assign tx_active = tx_pause_request_in & tx_pause_prio_enable_in;
  // Pending masked by live request, so a channel disabled this cycle is never issued
  assign pend_live = pend_reg & tx_active;
  // global goes alone, else all pending priorities share one frame
  assign issue_bits = pend_live[GLOB_IDX] ? {1'b1, 8'h00} : {1'b0, pend_live[7:0]};
  assign issue = (state_reg == TX_IDLE) && (pend_live != CH_NONE);

  // timers restart on start, on send and on resend
  assign restart = (tx_active & ~active_d_reg)
    | ((state_reg == TX_FLIGHT && tx_ctl_done_in) ? sent_reg : CH_NONE)
    | (tx_pause_resend_in ? tx_active : CH_NONE);

  generate
    for (gi = 0; gi < NCH; gi++) begin : g_tmr
      epf_refresh_timer u_tmr (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .run_in(tx_active[gi]),
        .restart_in(restart[gi]),
        .interval_in(tx_pause_refresh_interval_in[gi]),
        .expire_out(expire[gi])
      );
    end
  endgenerate

  // pending set; sets win over the issue clear
  assign pend_next = ((pend_reg & ~(issue ? issue_bits : CH_NONE))
    | (tx_active & ~active_d_reg) | expire
    | (tx_pause_resend_in ? tx_active : CH_NONE)) & tx_active;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pend_reg <= CH_NONE;
      active_d_reg <= CH_NONE;
    end else begin
      pend_reg <= pend_next;
      active_d_reg <= tx_active;
    end
  end

  // Offer, hand over, then wait for the framer to finish
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= TX_IDLE;
      frame_reg <= '0;
      sent_reg <= CH_NONE;
      tx_vld_reg <= CH_NONE;
    end else begin
      tx_vld_reg <= CH_NONE;
      unique case (state_reg)
        TX_IDLE: begin
          if (issue) begin
            state_reg <= TX_OFFER;
            sent_reg <= issue_bits;
            frame_reg.is_global <= issue_bits[GLOB_IDX];
            frame_reg.class_en <= issue_bits[7:0];
            frame_reg.quanta <= tx_pause_quanta_in;
          end
        end
        TX_OFFER: begin
          if (tx_ctl_ready_in) begin
            state_reg <= TX_FLIGHT;
          end
        end
        TX_FLIGHT: begin
          if (tx_ctl_done_in) begin
            state_reg <= TX_IDLE;
            tx_vld_reg <= sent_reg;
          end
        end
      endcase
    end
  end

  assign tx_ctl_valid_out = state_reg == TX_OFFER;
  assign tx_ctl_out = frame_reg;
  assign tx_pause_valid_out = tx_vld_reg;

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_glob_rx_gate: assert property (!glob_pause_rx_en_in |-> !rx_hit[8])
    else $error("global pause taken while disabled");
  chk_prio_rx_gate: assert property (!prio_pause_rx_en_in |-> rx_hit[7:0] == 8'h00)
    else $error("priority pause taken while disabled");
  chk_glob_etype_check: assert property (glob_pause_chk_ethertype_in && !etype_ok |-> !rx_hit[8])
    else $error("global pause with bad ethertype taken");
  chk_prio_mcast_check: assert property (prio_pause_chk_multicast_da_in && !prio_pause_chk_unicast_da_in
    && !da_is_mcast |-> rx_hit[7:0] == 8'h00)
    else $error("priority pause with bad multicast address taken");
  chk_req_set_hold: assert property (rx_hit != CH_NONE |=> (req_reg & $past(rx_hit)) == $past(rx_hit))
    else $error("request not raised for received pause");
  chk_ack_clears_req: assert property (1'b1 |=>
    (req_reg & $past(rx_pause_acknowledge_in) & ~$past(rx_hit)) == CH_NONE)
    else $error("acknowledged request still set");
  chk_glob_quanta_slot: assert property (rx_hit[8] |=> rx_pause_quanta_out[8] == $past(rx_ctl_in.quanta[0])
    && rx_valid_reg[8])
    else $error("global quanta not in slot 8");
  chk_tx_global_alone: assert property (tx_ctl_valid_out && tx_ctl_out.is_global |->
    tx_ctl_out.class_en == 8'h00)
    else $error("global frame mixed with priorities");
  chk_tx_enable_gate: assert property (issue |-> (issue_bits & ~tx_pause_prio_enable_in) == CH_NONE)
    else $error("pause issued for disabled channel");
  chk_tx_valid_report: assert property (state_reg == TX_FLIGHT && tx_ctl_done_in |=>
    tx_pause_valid_out == $past(sent_reg) ##1 tx_pause_valid_out == CH_NONE)
    else $error("transmit valid wrong after frame done");
  chk_resend_pending: assert property (tx_pause_resend_in && tx_active != CH_NONE |=>
    (pend_reg & $past(tx_active) & tx_active) == ($past(tx_active) & tx_active))
    else $error("resend did not mark active channels pending");

  cov_rx_global: cover property (rx_hit[8] ##[1:20] rx_pause_acknowledge_in[8]);
  cov_rx_prio: cover property (rx_hit[7:0] != 8'h00);
  cov_tx_global: cover property (tx_pause_valid_out[8]);
  cov_tx_resend: cover property (tx_pause_resend_in && state_reg == TX_FLIGHT);
endmodule

//--- epf_refresh_timer.sv
// Purpose: shared constants and types for pause flow control, plus the
//          per-channel refresh timer.
// Assumes: one core clock; all inputs come from logic on that clock.
// Notes:   interval counts core clock cycles; zero turns refresh off.
package epf_pkg;
  localparam int NCH = 9;
  localparam int GLOB_IDX = 8;
  localparam logic [15:0] ETYPE_MAC_CTL = 16'h8808;
  localparam logic [15:0] OPC_GLOBAL = 16'h0001;
  localparam logic [15:0] OPC_PRIO = 16'h0101;
  localparam logic [47:0] MCAST_CTL_DA = 48'h0180C2000001;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [8:0] CH_NONE = 9'h000;
  // Decoded MAC control frame from the receive parser
  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
    logic [7:0] class_en;
    logic [7:0][15:0] quanta;
  } epf_rx_ctl_t;
  // Pause frame order handed to the transmit framer
  typedef struct packed {
    logic is_global;
    logic [7:0] class_en;
    logic [8:0][15:0] quanta;
  } epf_tx_ctl_t;
endpackage

module epf_refresh_timer (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic [15:0] interval_in,
  output logic expire_out
);
  import epf_pkg::*;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic hit;

  // Terminal count; a zero interval never fires
  // Compare is >= so an interval cut below the running count fires at once, not after a wrap
  assign hit = run_in && !restart_in && (interval_in != TIMER_RST) && (cnt_reg >= interval_in);
  assign cnt_next = (!run_in || restart_in || hit) ? TIMER_RST : cnt_reg + 16'h0001;

  // Counter and registered expiry pulse
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cnt_reg <= TIMER_RST;
      expire_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expire_out <= hit;
    end
  end
endmodule

//--- epf_user_model.sv
// Purpose: user flow-control logic that answers receive pause requests.
// Assumes: core clock only; delay_in steady while a request is up.
// Notes:   delay of zero acks on the first edge that sees the request.
module epf_user_model (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] delay_in,
  input wire logic [8:0] rx_pause_req_in,
  output logic [8:0] rx_pause_acknowledge_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0][3:0] wait_reg;
  // ack each request
  // Ack falls on the edge after the request drops, so a later request is never acked early
  always_ff @(posedge core_clk_in) begin
    for (int i = 0; i < 9; i++) begin
      if (!rst_n_in || !rx_pause_req_in[i]) begin
        wait_reg[i] <= 4'h0;
        rx_pause_acknowledge_out[i] <= 1'b0;
      end else if (wait_reg[i] == delay_in) begin
        rx_pause_acknowledge_out[i] <= 1'b1;
      end else begin
        wait_reg[i] <= wait_reg[i] + 4'h1;
      end
    end
  end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for pause receive and transmit control.
// Assumes: framer side is played by the bench with ready held high.
// Notes:   refresh is shown with a short interval to keep the run brief.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import epf_pkg::*;
  localparam logic [47:0] ME = 48'h02AABBCCDD01;
  localparam logic [47:0] PEER = 48'h021122334455;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, rx_ctl_valid_in = 1'b0, tx_pause_resend_in = 1'b0;
  logic tx_ctl_ready_in = 1'b1, tx_ctl_done_in = 1'b0, tx_ctl_valid_out;
  logic glob_pause_rx_en_in = 1'b1, glob_pause_chk_unicast_da_in = 1'b1, glob_pause_chk_src_addr_in = 1'b1;
  logic glob_pause_chk_ethertype_in = 1'b1, glob_pause_chk_opcode_in = 1'b1, prio_pause_rx_en_in = 1'b1;
  logic prio_pause_chk_multicast_da_in = 1'b1, prio_pause_chk_unicast_da_in = 1'b1;
  logic prio_pause_chk_src_addr_in = 1'b1, prio_pause_chk_ethertype_in = 1'b1, prio_pause_chk_opcode_in = 1'b1;
  logic [47:0] station_addr_in = ME, pause_src_addr_in = PEER;
  logic [8:0] rx_pause_prio_enable_in = 9'h1FF, tx_pause_request_in = 9'h000, tx_pause_prio_enable_in = 9'h1FF;
  logic [8:0] rx_pause_acknowledge_in, rx_pause_req_out, rx_pause_valid_out, tx_pause_valid_out;
  logic [8:0][15:0] rx_pause_quanta_out, tx_pause_quanta_in, tx_pause_refresh_interval_in = '0;
  logic [3:0] ack_dly = 4'h3;
  epf_rx_ctl_t rx_ctl_in = '0;
  epf_tx_ctl_t tx_ctl_out;
  int err_count = 0, comparisons = 0, cycles = 0;

  epf_pause_ctl i_epf_pause_ctl (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .rx_ctl_valid_in(rx_ctl_valid_in),
    .rx_ctl_in(rx_ctl_in), .station_addr_in(station_addr_in), .pause_src_addr_in(pause_src_addr_in),
    .glob_pause_rx_en_in(glob_pause_rx_en_in), .glob_pause_chk_unicast_da_in(glob_pause_chk_unicast_da_in),
    .glob_pause_chk_src_addr_in(glob_pause_chk_src_addr_in),
    .glob_pause_chk_ethertype_in(glob_pause_chk_ethertype_in), .glob_pause_chk_opcode_in(glob_pause_chk_opcode_in),
    .prio_pause_rx_en_in(prio_pause_rx_en_in), .prio_pause_chk_multicast_da_in(prio_pause_chk_multicast_da_in),
    .prio_pause_chk_unicast_da_in(prio_pause_chk_unicast_da_in),
    .prio_pause_chk_src_addr_in(prio_pause_chk_src_addr_in),
    .prio_pause_chk_ethertype_in(prio_pause_chk_ethertype_in), .prio_pause_chk_opcode_in(prio_pause_chk_opcode_in),
    .rx_pause_prio_enable_in(rx_pause_prio_enable_in), .rx_pause_acknowledge_in(rx_pause_acknowledge_in),
    .rx_pause_req_out(rx_pause_req_out), .rx_pause_valid_out(rx_pause_valid_out),
    .rx_pause_quanta_out(rx_pause_quanta_out), .tx_pause_request_in(tx_pause_request_in),
    .tx_pause_quanta_in(tx_pause_quanta_in), .tx_pause_refresh_interval_in(tx_pause_refresh_interval_in),
    .tx_pause_resend_in(tx_pause_resend_in), .tx_pause_prio_enable_in(tx_pause_prio_enable_in),
    .tx_ctl_valid_out(tx_ctl_valid_out), .tx_ctl_out(tx_ctl_out), .tx_ctl_ready_in(tx_ctl_ready_in),
    .tx_ctl_done_in(tx_ctl_done_in), .tx_pause_valid_out(tx_pause_valid_out));
  epf_user_model i_epf_user_model (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .delay_in(ack_dly),
    .rx_pause_req_in(rx_pause_req_out), .rx_pause_acknowledge_out(rx_pause_acknowledge_in));

  // Clock and hang guard; a full run takes well under a thousand cycles
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      close_out;
    end
  end

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  function automatic epf_rx_ctl_t mk(logic [47:0] da, sa, logic [15:0] et, op, logic [7:0] cls);
    mk = '0;
    mk.da = da;
    mk.sa = sa;
    mk.etype = et;
    mk.opcode = op;
    mk.class_en = cls;
    for (int i = 0; i < 8; i++) mk.quanta[i] = {cls ^ 8'h5A, 4'h3, 4'(i)};
  endfunction

  // One frame from the parser; exp lists the channels that must be hit
  task automatic rx_send(input epf_rx_ctl_t f, input logic [8:0] exp);
    rx_ctl_valid_in <= 1'b1;
    rx_ctl_in <= f;
    @(posedge core_clk_in) rx_ctl_valid_in <= 1'b0;
    #1;
    chk(rx_pause_valid_out === (exp & rx_pause_prio_enable_in), "rx valid bits");
    chk(rx_pause_req_out === (exp & rx_pause_prio_enable_in), "rx request bits");
    for (int i = 0; i < 9; i++) begin
      if (exp[i]) chk(rx_pause_quanta_out[i] === f.quanta[i == 8 ? 0 : i], "rx quanta");
    end
    @(posedge core_clk_in);
  endtask

  task automatic wait_clear;
    int n;
    n = 0;
    #1;
    while (rx_pause_req_out !== 9'h000 && n < 30) begin
      @(posedge core_clk_in) #1;
      n++;
    end
    chk(rx_pause_req_out === 9'h000, "request not cleared by ack");
    @(posedge core_clk_in);
  endtask

  // Framer side: take the order, check it, finish it, check the report
  task automatic tx_frame(input logic [8:0] bits);
    int n;
    n = 0;
    #1;
    while (tx_ctl_valid_out !== 1'b1 && n < 60) begin
      @(posedge core_clk_in) #1;
      n++;
    end
    chk(tx_ctl_valid_out === 1'b1 && tx_ctl_out.is_global === bits[8], "tx order kind");
    chk(bits[8] || tx_ctl_out.class_en === bits[7:0], "tx order classes");
    chk(tx_ctl_out.quanta === tx_pause_quanta_in, "tx order quanta");
    @(posedge core_clk_in);
    @(posedge core_clk_in) tx_ctl_done_in <= 1'b1;
    @(posedge core_clk_in) tx_ctl_done_in <= 1'b0;
    #1;
    chk(tx_pause_valid_out === bits, "tx sent bits");
    @(posedge core_clk_in);
  endtask

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge core_clk_in) #1;
      if (tx_ctl_valid_out !== 1'b0) seen = 1'b1;
    end
    chk(!seen, "unexpected tx order");
    @(posedge core_clk_in);
  endtask

  task automatic rx_glob;
    rx_send(mk(ME, PEER, ETYPE_MAC_CTL, OPC_GLOBAL, 8'h00), 9'h100);
    wait_clear;
    rx_send(mk(ME, 48'h0, ETYPE_MAC_CTL, OPC_GLOBAL, 8'h00), 9'h000);
    rx_send(mk(ME, PEER, 16'h0800, OPC_GLOBAL, 8'h00), 9'h000);
    rx_send(mk(48'h020000000009, PEER, ETYPE_MAC_CTL, OPC_GLOBAL, 8'h00), 9'h000);
    rx_send(mk(ME, PEER, ETYPE_MAC_CTL, 16'h0002, 8'h00), 9'h000);
    glob_pause_chk_src_addr_in <= 1'b0;
    rx_send(mk(ME, 48'h0, ETYPE_MAC_CTL, OPC_GLOBAL, 8'h00), 9'h100);
    wait_clear;
    glob_pause_rx_en_in <= 1'b0;
    rx_send(mk(ME, PEER, ETYPE_MAC_CTL, OPC_GLOBAL, 8'h00), 9'h000);
    glob_pause_rx_en_in <= 1'b1;
  endtask

  task automatic rx_prio;
    ack_dly <= 4'h0;
    rx_pause_prio_enable_in <= 9'h1FB;
    rx_send(mk(MCAST_CTL_DA, PEER, ETYPE_MAC_CTL, OPC_PRIO, 8'h05), 9'h005);
    wait_clear;
    rx_pause_prio_enable_in <= 9'h1FF;
    @(posedge core_clk_in) #1;
    chk(rx_pause_req_out[2] === 1'b1, "masked request lost");
    wait_clear;
    rx_send(mk(48'h020000000009, PEER, ETYPE_MAC_CTL, OPC_PRIO, 8'h81), 9'h000);
    prio_pause_rx_en_in <= 1'b0;
    rx_send(mk(MCAST_CTL_DA, PEER, ETYPE_MAC_CTL, OPC_PRIO, 8'h81), 9'h000);
    prio_pause_rx_en_in <= 1'b1;
  endtask

  task automatic tx_flow;
    tx_pause_request_in <= 9'h100;
    tx_frame(9'h100);
    tx_pause_prio_enable_in <= 9'h1F7;
    tx_pause_request_in <= 9'h108;
    quiet(20);
    tx_pause_prio_enable_in <= 9'h1FF;
    tx_frame(9'h008);
    tx_pause_resend_in <= 1'b1;
    @(posedge core_clk_in) tx_pause_resend_in <= 1'b0;
    tx_frame(9'h100);
    tx_frame(9'h008);
    tx_pause_refresh_interval_in[3] <= 16'h0028;
    quiet(25);
    tx_frame(9'h008);
    tx_pause_refresh_interval_in[3] <= 16'h0000;
    tx_pause_request_in <= 9'h000;
  endtask

  task automatic close_out;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 9; i++) tx_pause_quanta_in[i] = 16'h0100 + 16'(i);
    repeat (6) @(posedge core_clk_in);
    // Outputs have been in reset for several edges here, so no race with the launch edge
    chk(rx_pause_req_out === 9'h000 && rx_pause_valid_out === 9'h000 && rx_pause_quanta_out === '0, "rx reset state");
    chk(tx_ctl_valid_out === 1'b0 && tx_ctl_out === '0 && tx_pause_valid_out === 9'h000, "tx reset state");
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    rx_glob();
    rx_prio();
    tx_flow();
    close_out;
  end
endmodule
